/* File: rtl/updown_timer_consts.svh */
`ifndef UPDOWN_TIMER_CONSTS_SVH
`define UPDOWN_TIMER_CONSTS_SVH

// ==================================================================
// register offsets (byte addresses)
`define OFS_TIMER_CTL 8'h00
`define OFS_COUNT_LIMIT 8'h04
`define OFS_COUNT_VALUE 8'h08
`define OFS_COUNTER_STATUS 8'h0c
`define OFS_INT_FLAG 8'h10
`define OFS_INT_ENABLE 8'h14
`define OFS_CLOCK_SELECT 8'h18
`define OFS_CC_CTRL 8'h1c

// ==================================================================
// field positions
`define CTL_MODULE_ENABLE 0
`define CTL_PRESET 1
`define CTL_RUN 2
`define CTL_DIR_LSB 4
`define CTL_SINGLE_PASS 6
`define CTL_LIMIT_BUSY 8
`define STATUS_RUNNING 0
`define STATUS_UP 1
`define FLAG_MAX 0
`define FLAG_ZERO 1
`define CC_FIELD_W 6
`define CC_STRIDE 8
`define UNMAPPED_ADDR 8'hff

// ==================================================================
// reset values
`define LIMIT_RESET 16'hffff
`define COUNT_RESET 16'h0000

`endif

/* File: rtl/updown_timer_pkg.sv */
package updown_timer_pkg;

  typedef enum logic [1:0] {
    DIR_UP = 2'h0,
    DIR_DOWN = 2'h1,
    DIR_UPDOWN = 2'h2
  } count_direction_e;

  typedef enum logic [1:0] {
    SRC_COUNT_CLOCK = 2'h0,
    SRC_EXT_RISE = 2'h1,
    SRC_EXT_FALL = 2'h2
  } count_source_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DATA = 2'b10
  } bus_phase_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_access_s;

endpackage

/* File: rtl/count_tick_gen.sv */
module count_tick_gen (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic channel_count_clock,
  input wire logic external_count_input,
  input wire updown_timer_pkg::count_source_e source,
  output logic tick
);

  logic [1:0] pin;
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] hist_r;
  logic [1:0] rise;
  logic [1:0] fall;
  logic tick_r;
  logic tick_nxt;

  assign pin = {external_count_input, channel_count_clock};

  // ==================================================================
  // two-stage sync and edge detect per input
  for (genvar i = 0; i < 2; i++) begin : g_pin
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        sync1_r[i] <= 1'b0;
        sync2_r[i] <= 1'b0;
        hist_r[i] <= 1'b0;
      end else begin
        sync1_r[i] <= pin[i];
        sync2_r[i] <= sync1_r[i];
        hist_r[i] <= sync2_r[i];
      end
    end
    assign rise[i] = sync2_r[i] & ~hist_r[i];
    assign fall[i] = ~sync2_r[i] & hist_r[i];
  end

  assign tick_nxt = (source == updown_timer_pkg::SRC_EXT_RISE) ? rise[1] :
                    (source == updown_timer_pkg::SRC_EXT_FALL) ? fall[1] : rise[0];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) tick_r <= 1'b0;
    else tick_r <= tick_nxt;
  end

  assign tick = tick_r;

endmodule

/* File: rtl/ahb_reg_slave.sv */
`include "updown_timer_consts.svh"

module ahb_reg_slave (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] rdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output updown_timer_pkg::reg_access_s access
);

  updown_timer_pkg::bus_phase_e phase_r;
  logic [7:0] addr_r;
  logic write_r;
  logic ready_r;
  logic [31:0] rdata_r;
  logic take;
  logic word;
  logic in_data;

  assign word = (hsize == 3'h2) && (haddr[31:8] == 24'h000000);
  assign take = hsel && htrans[1] && hready;
  assign in_data = (phase_r == updown_timer_pkg::BUS_DATA);
  assign access = '{wr: in_data && write_r, rd: in_data && !write_r,
                    addr: addr_r, wdata: hwdata};

  // ==================================================================
  // one wait state per transfer so hrdata comes from a flop
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phase_r <= updown_timer_pkg::BUS_IDLE;
      ready_r <= 1'b1;
      addr_r <= 8'h00;
      write_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      case (phase_r)
        updown_timer_pkg::BUS_IDLE: begin
          if (take) begin
            phase_r <= updown_timer_pkg::BUS_DATA;
            ready_r <= 1'b0;
            addr_r <= word ? haddr[7:0] : `UNMAPPED_ADDR;
            write_r <= hwrite;
          end
        end
        default: begin
          phase_r <= updown_timer_pkg::BUS_IDLE;
          ready_r <= 1'b1;
          if (!write_r) rdata_r <= rdata;
        end
      endcase
    end
  end

  assign hreadyout = ready_r;
  assign hrdata = rdata_r;

endmodule

/* File: rtl/updown_timer_counter.sv */
// Chosen here: the address map and the AHB-Lite slave port.
`include "updown_timer_consts.svh"

// Behaviour
// - 16-bit counter steps once per count edge
// - direction field plus single-pass bit: six modes
// - limit register bounds count range
// - preset clears, or loads limit in down
// - up count past limit clears to zero
// - run bit starts counting while module enable is set
// - running status mirrors counter activity
// - direction status: 1 up, 0 down
// - repeat up wraps, honours raised/lowered limit
// - single-pass up returns zero then stops
// - repeat down reloads; new limit at underflow
// - single-pass down reloads limit then stops
// - repeat up/down bounces; new limit at the next up step or at zero
// - single-pass up/down stops at zero going down
// - circuit mode bit: compare or capture
// - flags clear on write one
// - external input counts rising or inverted edges
module updown_timer_counter #(
  parameter int CIRCUITS = 2
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic channel_count_clock,
  input wire logic external_count_input,
  output logic [15:0] current_count_value,
  output logic count_max_event,
  output logic count_zero_event,
  output logic [CIRCUITS-1:0] circuit_mode_select,
  output logic [CIRCUITS*`CC_FIELD_W-1:0] compare_capture_ctrl
);

  updown_timer_pkg::reg_access_s acc;
  updown_timer_pkg::count_direction_e dir_r;
  updown_timer_pkg::count_source_e src_r;
  logic [31:0] rdata;
  logic tick;
  logic enable_r;
  logic run_r;
  logic single_r;
  logic up_r;
  logic up_nxt;
  logic busy_r;
  logic [15:0] limit_r;
  logic [15:0] act_lim_r;
  logic [15:0] lim_eff;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [1:0] flag_r;
  logic [1:0] inten_r;
  logic max_r;
  logic zero_r;
  logic [CIRCUITS*`CC_FIELD_W-1:0] cc_r;
  logic wr_ctl;
  logic wr_limit;
  logic wr_flag;
  logic wr_inten;
  logic wr_clk;
  logic wr_cc;
  logic preset_wr;
  logic counting;
  logic step;
  logic auto_stop;
  logic lim_load;
  logic max_evt;
  logic zero_evt;

  // ==================================================================
  // bus front end and count edge source
  ahb_reg_slave u_slave (
    .core_clk(core_clk),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .rdata(rdata),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .access(acc)
  );

  count_tick_gen u_tick (
    .core_clk(core_clk),
    .reset(reset),
    .channel_count_clock(channel_count_clock),
    .external_count_input(external_count_input),
    .source(src_r),
    .tick(tick)
  );

  assign hresp = 1'b0;
  // ==================================================================
  // address decode
  assign wr_ctl = acc.wr && (acc.addr == `OFS_TIMER_CTL);
  assign wr_limit = acc.wr && (acc.addr == `OFS_COUNT_LIMIT);
  assign wr_flag = acc.wr && (acc.addr == `OFS_INT_FLAG);
  assign wr_inten = acc.wr && (acc.addr == `OFS_INT_ENABLE);
  assign wr_clk = acc.wr && (acc.addr == `OFS_CLOCK_SELECT);
  assign wr_cc = acc.wr && (acc.addr == `OFS_CC_CTRL);
  assign preset_wr = wr_ctl && acc.wdata[`CTL_PRESET];

  always_comb begin
    rdata = 32'h00000000;
    if (acc.addr == `OFS_TIMER_CTL) begin
      rdata[`CTL_MODULE_ENABLE] = enable_r;
      rdata[`CTL_RUN] = run_r;
      rdata[`CTL_DIR_LSB +: 2] = dir_r;
      rdata[`CTL_SINGLE_PASS] = single_r;
      rdata[`CTL_LIMIT_BUSY] = busy_r;
    end else if (acc.addr == `OFS_COUNT_LIMIT) begin
      rdata[15:0] = limit_r;
    end else if (acc.addr == `OFS_COUNT_VALUE) begin
      rdata[15:0] = cnt_r;
    end else if (acc.addr == `OFS_COUNTER_STATUS) begin
      rdata[`STATUS_RUNNING] = counting;
      rdata[`STATUS_UP] = up_r;
    end else if (acc.addr == `OFS_INT_FLAG) begin
      rdata[1:0] = flag_r;
    end else if (acc.addr == `OFS_INT_ENABLE) begin
      rdata[1:0] = inten_r;
    end else if (acc.addr == `OFS_CLOCK_SELECT) begin
      rdata[1:0] = src_r;
    end else if (acc.addr == `OFS_CC_CTRL) begin
      for (int i = 0; i < CIRCUITS; i++) begin
        rdata[i*`CC_STRIDE +: `CC_FIELD_W] = cc_r[i*`CC_FIELD_W +: `CC_FIELD_W];
      end
    end
  end

  // ==================================================================
  // counter step
  assign counting = run_r && enable_r;
  assign step = counting && tick && !preset_wr;
  assign lim_eff = busy_r ? limit_r : act_lim_r;
  assign max_evt = step && (cnt_nxt == lim_eff);
  assign zero_evt = step && (cnt_nxt == 16'h0000);

  always_comb begin
    cnt_nxt = cnt_r;
    up_nxt = up_r;
    auto_stop = 1'b0;
    lim_load = busy_r && !counting;
    if (preset_wr) begin
      lim_load = busy_r;
      if (dir_r == updown_timer_pkg::DIR_DOWN) begin
        cnt_nxt = lim_eff;
        up_nxt = 1'b0;
      end else begin
        cnt_nxt = 16'h0000;
        up_nxt = 1'b1;
      end
    end else if (step && up_r) begin
      lim_load = busy_r;
      if (cnt_r > lim_eff) begin
        cnt_nxt = 16'h0000;
      end else if (cnt_r == lim_eff) begin
        if (dir_r == updown_timer_pkg::DIR_UPDOWN && lim_eff != 16'h0000) begin
          cnt_nxt = cnt_r - 16'h0001;
          up_nxt = 1'b0;
          auto_stop = single_r && (lim_eff == 16'h0001);
        end else begin
          cnt_nxt = 16'h0000;
          auto_stop = single_r;
        end
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end else if (step) begin
      if (cnt_r == 16'h0000) begin
        lim_load = busy_r;
        if (dir_r == updown_timer_pkg::DIR_UPDOWN) begin
          up_nxt = 1'b1;
          cnt_nxt = (lim_eff == 16'h0000) ? 16'h0000 : 16'h0001;
        end else begin
          cnt_nxt = lim_eff;
          auto_stop = single_r;
        end
      end else begin
        cnt_nxt = cnt_r - 16'h0001;
        if (dir_r == updown_timer_pkg::DIR_UPDOWN && cnt_r == 16'h0001) begin
          auto_stop = single_r;
        end
      end
    end
  end

  // ==================================================================
  // control and counter registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      enable_r <= 1'b0;
      run_r <= 1'b0;
      dir_r <= updown_timer_pkg::DIR_UP;
      single_r <= 1'b0;
    end else if (wr_ctl) begin
      enable_r <= acc.wdata[`CTL_MODULE_ENABLE];
      run_r <= acc.wdata[`CTL_RUN];
      dir_r <= updown_timer_pkg::count_direction_e'(acc.wdata[`CTL_DIR_LSB +: 2]);
      single_r <= acc.wdata[`CTL_SINGLE_PASS];
    end else if (auto_stop) begin
      run_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= `COUNT_RESET;
      up_r <= 1'b1;
      max_r <= 1'b0;
      zero_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      up_r <= up_nxt;
      max_r <= max_evt;
      zero_r <= zero_evt;
    end
  end

  // pending limit reaches the counter at a safe point
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      limit_r <= `LIMIT_RESET;
      act_lim_r <= `LIMIT_RESET;
      busy_r <= 1'b0;
    end else begin
      if (wr_limit) limit_r <= acc.wdata[15:0];
      if (lim_load) act_lim_r <= limit_r;
      busy_r <= wr_limit || (busy_r && !lim_load);
    end
  end

  // flags: hardware set wins over write-one clear
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flag_r <= 2'h0;
      inten_r <= 2'h0;
      src_r <= updown_timer_pkg::SRC_COUNT_CLOCK;
    end else begin
      flag_r <= (flag_r & ~(wr_flag ? acc.wdata[1:0] : 2'h0)) | {zero_evt, max_evt};
      if (wr_inten) inten_r <= acc.wdata[1:0];
      if (wr_clk) src_r <= updown_timer_pkg::count_source_e'(acc.wdata[1:0]);
    end
  end

  for (genvar i = 0; i < CIRCUITS; i++) begin : g_cc
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) cc_r[i*`CC_FIELD_W +: `CC_FIELD_W] <= '0;
      else if (wr_cc) begin
        cc_r[i*`CC_FIELD_W +: `CC_FIELD_W] <= acc.wdata[i*`CC_STRIDE +: `CC_FIELD_W];
      end
    end
    assign circuit_mode_select[i] = cc_r[i*`CC_FIELD_W];
  end

  assign current_count_value = cnt_r;
  assign count_max_event = max_r;
  assign count_zero_event = zero_r;
  assign compare_capture_ctrl = cc_r;

  // ==================================================================
  // checks
  sequence s_idle_limit_write;
    wr_limit && !counting ##1 !wr_limit && !counting;
  endsequence

  sequence s_up_top;
    step && up_r && (cnt_r == lim_eff) && (dir_r == updown_timer_pkg::DIR_UP);
  endsequence

  a_preset_up_clear: assert property (@(posedge core_clk) disable iff (reset)
    preset_wr && dir_r != updown_timer_pkg::DIR_DOWN |=> cnt_r == 16'h0000 && up_r)
    else $error("preset did not clear counter");

  a_preset_down_load: assert property (@(posedge core_clk) disable iff (reset)
    preset_wr && dir_r == updown_timer_pkg::DIR_DOWN |=> cnt_r == $past(lim_eff) && !up_r)
    else $error("preset did not load limit");

  a_idle_count_hold: assert property (@(posedge core_clk) disable iff (reset)
    !counting && !preset_wr |=> cnt_r == $past(cnt_r))
    else $error("stopped counter moved");

  a_up_wrap_zero: assert property (@(posedge core_clk) disable iff (reset)
    s_up_top |=> cnt_r == 16'h0000 && (!run_r || !$past(single_r) || $past(wr_ctl)))
    else $error("up count did not wrap");

  a_single_stop: assert property (@(posedge core_clk) disable iff (reset)
    auto_stop && !wr_ctl |=> !run_r ##1 cnt_r == $past(cnt_r) || $past(preset_wr))
    else $error("self stop failed");

  a_down_reload: assert property (@(posedge core_clk) disable iff (reset)
    step && !up_r && cnt_r == 16'h0000 && dir_r == updown_timer_pkg::DIR_DOWN
    |=> cnt_r == $past(lim_eff))
    else $error("underflow did not reload");

  a_run_start: assert property (@(posedge core_clk) disable iff (reset)
    wr_ctl && acc.wdata[`CTL_RUN] && acc.wdata[`CTL_MODULE_ENABLE] |=> counting)
    else $error("run write did not start");

  a_count_step: assert property (@(posedge core_clk) disable iff (reset)
    step && up_r && cnt_r < lim_eff |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("up step wrong");

  a_busy_idle_clear: assert property (@(posedge core_clk) disable iff (reset)
    s_idle_limit_write |=> !busy_r && act_lim_r == limit_r)
    else $error("idle limit write not applied");

  a_updown_turn: assert property (@(posedge core_clk) disable iff (reset)
    step && up_r && dir_r == updown_timer_pkg::DIR_UPDOWN && cnt_r == lim_eff
    && lim_eff != 16'h0000 |=> !up_r)
    else $error("up/down did not turn");

  a_flag_set_wins: assert property (@(posedge core_clk) disable iff (reset)
    max_evt |=> flag_r[`FLAG_MAX])
    else $error("max flag lost");

endmodule

/* File: bench/updown_timer_counter_block_tb.sv */
`include "updown_timer_consts.svh"

module updown_timer_counter_block_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [31:0] mode;
    logic [31:0] limit;
    int n;
    logic [31:0] cnt;
    logic [31:0] st;
    logic [31:0] mask;
    int nmax;
  } row_s;

  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic cnt_clk = 1'b0;
  logic ext_in = 1'b0;
  wire logic hreadyout;
  wire logic [31:0] hrdata;
  wire logic hresp;
  wire logic [15:0] count;
  wire logic max_ev;
  wire logic zero_ev;
  wire logic [1:0] cmode;
  wire logic [11:0] cctrl;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int max_seen = 0;
  int zero_seen = 0;
  int m0;
  int z0;
  logic [31:0] q;
  logic [31:0] q2;
  row_s rows [8];

  updown_timer_counter #(.CIRCUITS(2)) dut (
    .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .channel_count_clock(cnt_clk), .external_count_input(ext_in),
    .current_count_value(count), .count_max_event(max_ev), .count_zero_event(zero_ev),
    .circuit_mode_select(cmode), .compare_capture_ctrl(cctrl)
  );

  // ==================================================================
  // clock, timeout, event monitor
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (max_ev === 1'b1) max_seen <= max_seen + 1;
    if (zero_ev === 1'b1) zero_seen <= zero_seen + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      close_out();
    end
  end

  // ==================================================================
  // helpers
  task automatic close_out();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t pin got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge core_clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask

  // stop, set limit, preset, then run
  task automatic cfg(input logic [31:0] mode, input logic [31:0] lim);
    wr(`OFS_TIMER_CTL, 32'h1 | mode);
    wr(`OFS_COUNT_LIMIT, lim);
    wr(`OFS_TIMER_CTL, 32'h3 | mode);
    wr(`OFS_TIMER_CTL, 32'h5 | mode);
  endtask

  task automatic ticks(input int n, input bit ext);
    repeat (n) begin
      @(posedge core_clk);
      if (ext) ext_in <= 1'b1;
      else cnt_clk <= 1'b1;
      repeat (3) @(posedge core_clk);
      if (ext) ext_in <= 1'b0;
      else cnt_clk <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
  endtask

  // ==================================================================
  // main sequence
  initial begin
    rows[0] = '{32'h00, 32'h2, 4, 32'h1, 32'h3, 32'h3, 1};
    rows[1] = '{32'h10, 32'h2, 3, 32'h2, 32'h1, 32'h3, 1};
    rows[2] = '{32'h20, 32'h2, 3, 32'h1, 32'h1, 32'h3, 1};
    rows[3] = '{32'h30, 32'h3, 5, 32'h1, 32'h3, 32'h3, 1};
    rows[4] = '{32'h40, 32'h2, 5, 32'h0, 32'h0, 32'h1, 1};
    rows[5] = '{32'h50, 32'h2, 5, 32'h2, 32'h0, 32'h1, 1};
    rows[6] = '{32'h60, 32'h2, 6, 32'h0, 32'h0, 32'h1, 1};
    rows[7] = '{32'h60, 32'h1, 4, 32'h0, 32'h0, 32'h1, 1};
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    chk_pin(hreadyout, 1);
    chk_pin(hresp, 0);
    chk_pin(count, 0);
    rd(`OFS_COUNT_LIMIT, q);
    chk_reg(q, 32'hffff);
    rd(`OFS_COUNTER_STATUS, q);
    chk_reg(q, 32'h2);
    rd(`UNMAPPED_ADDR, q);
    chk_reg(q, 32'h0);
    $display("test reset done");

    foreach (rows[i]) begin
      cfg(rows[i].mode, rows[i].limit);
      m0 = max_seen;
      ticks(rows[i].n, 1'b0);
      rd(`OFS_COUNT_VALUE, q);
      rd(`OFS_COUNT_VALUE, q2);
      chk_reg(q, rows[i].cnt);
      chk_reg(q2, rows[i].cnt);
      chk_pin(count, rows[i].cnt);
      rd(`OFS_COUNTER_STATUS, q);
      chk_reg(q & rows[i].mask, rows[i].st);
      rd(`OFS_TIMER_CTL, q);
      chk_reg(q & 32'h4, (rows[i].st & 32'h1) << 2);
      if (rows[i].nmax >= 0) chk_pin(max_seen - m0, rows[i].nmax);
      $display("test row %0d done", i);
    end

    // lowered limit mid count, busy, hold while stopped, preset
    cfg(32'h00, 32'ha);
    ticks(5, 1'b0);
    rd(`OFS_TIMER_CTL, q);
    chk_reg(q & 32'h100, 32'h0);
    wr(`OFS_COUNT_LIMIT, 32'h3);
    rd(`OFS_TIMER_CTL, q);
    chk_reg(q & 32'h100, 32'h100);
    ticks(1, 1'b0);
    chk_pin(count, 0);
    rd(`OFS_TIMER_CTL, q);
    chk_reg(q & 32'h100, 32'h0);
    ticks(1, 1'b0);
    wr(`OFS_TIMER_CTL, 32'h1);
    ticks(2, 1'b0);
    chk_pin(count, 1);
    rd(`OFS_COUNTER_STATUS, q);
    chk_reg(q & 32'h1, 32'h0);
    wr(`OFS_TIMER_CTL, 32'h3);
    repeat (3) @(posedge core_clk);
    chk_pin(count, 0);
    $display("test limit done");

    // new limit in down mode waits for underflow
    cfg(32'h10, 32'h4);
    chk_pin(count, 4);
    wr(`OFS_COUNT_LIMIT, 32'h6);
    ticks(3, 1'b0);
    chk_pin(count, 1);
    ticks(2, 1'b0);
    chk_pin(count, 6);
    $display("test down limit done");

    // external falling edges, flags write one to clear
    wr(`OFS_CLOCK_SELECT, 32'h2);
    cfg(32'h00, 32'h1);
    wr(`OFS_INT_FLAG, 32'h3);
    rd(`OFS_INT_FLAG, q);
    chk_reg(q, 32'h0);
    z0 = zero_seen;
    ticks(2, 1'b1);
    chk_pin(count, 0);
    chk_pin(zero_seen - z0, 1);
    rd(`OFS_INT_FLAG, q);
    chk_reg(q, 32'h3);
    wr(`OFS_INT_FLAG, 32'h1);
    rd(`OFS_INT_FLAG, q);
    chk_reg(q, 32'h2);
    wr(`OFS_INT_ENABLE, 32'h3);
    rd(`OFS_INT_ENABLE, q);
    chk_reg(q, 32'h3);
    $display("test external done");

    // circuit modes set independently
    wr(`OFS_CC_CTRL, 32'h2d00);
    rd(`OFS_CC_CTRL, q);
    chk_reg(q, 32'h2d00);
    chk_pin({30'h0, cmode}, 32'h2);
    chk_pin({20'h0, cctrl}, 32'hb40);
    $display("test circuits done");

    // reset in mid run
    cfg(32'h00, 32'h5);
    ticks(2, 1'b1);
    chk_pin(count, 2);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    chk_pin(count, 0);
    chk_pin({30'h0, cmode}, 32'h0);
    rd(`OFS_COUNTER_STATUS, q);
    chk_reg(q, 32'h2);
    rd(`OFS_COUNT_LIMIT, q);
    chk_reg(q, 32'hffff);
    $display("test mid reset done");
    close_out();
  end
endmodule
